/* File: core/rct_timer.sv */
`timescale 1ns/1ps
// Summary of operation
// - Unsplit, no capture: 16-bit count, reload on wrap, set high overflow flag.
// - 16-bit auto-reload: interrupt request on every overflow when enabled.
// - 16-bit: low-byte wrap also requests interrupt if low irq enable set.
// - Split, no capture: two 8-bit timers, each reloads from its reload byte.
// - Run bit gates counting but not captures; in split mode only the high counter.
// - Per byte: system_clock if select set, else system_clock/12 or external/8.
// - External divided clock is synchronised to the system clock first.
// - Split: high wrap sets high flag, low wrap sets low flag.
// - Split: high overflow requests interrupt; with low enable either overflow does.
// - Hardware never clears overflow flags; software clears and inspects both.
// - Low overflow flag set on every low byte wrap, in every mode.
// - Capture source: 0 start-of-frame, 1 low-frequency oscillator falling edge.
// - Capture unsplit: 16-bit wrap count; event copies count to reload, interrupt.
// - Capture split: two 8-bit wrap counters; event copies both bytes, interrupt.
// - Split: external select applies to both bytes, system_clock select overrides.
module rct_timer
  import rct_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic [3:0]  i_pstrb,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // Timing sources
  input  wire logic        i_ext_clk,
  input  wire logic        i_usb_sof,
  input  wire logic        i_lfo_clk,
  // Interrupt controller enable and request
  input  wire logic        i_timer_irq_enable,
  output logic             o_irq_request
);

  // ----------------------------------------------------------------
  // Event conditioning
  // ----------------------------------------------------------------
  logic ext_rise;
  logic sof_rise;
  logic lfo_fall;
  logic sys_div_tick;
  logic ext_div_tick;

  rct_sync_edge u_ext_sync (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_level (i_ext_clk),
    .o_rise  (ext_rise),
    .o_fall  ()
  );

  rct_sync_edge u_sof_sync (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_level (i_usb_sof),
    .o_rise  (sof_rise),
    .o_fall  ()
  );

  rct_sync_edge u_lfo_sync (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_level (i_lfo_clk),
    .o_rise  (),
    .o_fall  (lfo_fall)
  );

  rct_tick_gen u_ticks (
    .i_clk          (i_clk),
    .i_rst          (i_rst),
    .i_ext_rise     (ext_rise),
    .o_sys_div_tick (sys_div_tick),
    .o_ext_div_tick (ext_div_tick)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  ctrl;
    logic [1:0]  clk_sel;
    logic [7:0]  reload_low_byte;
    logic [7:0]  reload_high_byte;
    logic [7:0]  count_low_byte;
    logic [7:0]  count_high_byte;
    logic [31:0] rdata;
    logic        irq_pulse;
  } rct_tm_type;

  rct_tm_type state;
  rct_tm_type next_state;

  // Control field views
  logic split_mode;
  logic capture_enable;
  logic run_control;
  logic low_irq_en;
  logic ext_sel;
  logic tick_lo;
  logic tick_hi;
  logic lo_en;
  logic hi_en;
  logic lo_wrap;
  logic hi_wrap;
  logic capture_evt;
  logic apb_access;
  logic apb_wr;
  logic wr_ctrl;

  assign split_mode     = state.ctrl[RCT_BIT_SPLIT];
  assign capture_enable = state.ctrl[RCT_BIT_CAPTURE_EN];
  assign run_control    = state.ctrl[RCT_BIT_RUN];
  assign low_irq_en     = state.ctrl[RCT_BIT_LOW_IRQ_EN];
  assign ext_sel        = state.ctrl[RCT_BIT_EXT_CLK];

  // ----------------------------------------------------------------
  // Clock selection per byte
  // ----------------------------------------------------------------
  // High byte select only matters when split; 16-bit mode uses the low select
  logic hi_system_clock;
  assign hi_system_clock = split_mode ? state.clk_sel[RCT_BIT_HI_SYSTEM_CLOCK]
                                : state.clk_sel[RCT_BIT_LO_SYSTEM_CLOCK];
  assign tick_lo = state.clk_sel[RCT_BIT_LO_SYSTEM_CLOCK] ? 1'b1
                 : (ext_sel ? ext_div_tick : sys_div_tick);
  assign tick_hi = hi_system_clock ? 1'b1
                 : (ext_sel ? ext_div_tick : sys_div_tick);

  // Split mode keeps the low counter always running
  assign lo_en = split_mode ? tick_lo : (tick_lo & run_control);
  assign hi_en = split_mode ? (tick_hi & run_control)
                            : (lo_en & (state.count_low_byte == RCT_BYTE_MAX));

  assign lo_wrap = lo_en & (state.count_low_byte == RCT_BYTE_MAX);
  assign hi_wrap = hi_en & (state.count_high_byte == RCT_BYTE_MAX);

  // Captures only act while capture mode is selected
  assign capture_evt = capture_enable &
                       (state.ctrl[RCT_BIT_CAP_SRC] ? lfo_fall : sof_rise);

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign apb_access = i_psel & i_penable;
  assign apb_wr     = apb_access & i_pwrite & i_pstrb[0];
  assign wr_ctrl    = apb_wr & (i_paddr == RCT_OFF_CTRL);

  logic addr_ok;
  assign addr_ok = (i_paddr == RCT_OFF_CTRL) || (i_paddr == RCT_OFF_CLK_SEL) ||
                   (i_paddr == RCT_OFF_RELOAD_LO) || (i_paddr == RCT_OFF_RELOAD_HI) ||
                   (i_paddr == RCT_OFF_COUNT_LO) || (i_paddr == RCT_OFF_COUNT_HI);

  always_comb begin
    next_state           = state;
    next_state.irq_pulse = 1'b0;

    // Software writes land first; counting below may override them
    if (apb_wr) begin
      unique case (i_paddr)
        RCT_OFF_CTRL:      next_state.ctrl             = i_pwdata[7:0];
        RCT_OFF_CLK_SEL:   next_state.clk_sel          = i_pwdata[1:0];
        RCT_OFF_RELOAD_LO: next_state.reload_low_byte  = i_pwdata[7:0];
        RCT_OFF_RELOAD_HI: next_state.reload_high_byte = i_pwdata[7:0];
        RCT_OFF_COUNT_LO:  next_state.count_low_byte   = i_pwdata[7:0];
        RCT_OFF_COUNT_HI:  next_state.count_high_byte  = i_pwdata[7:0];
        default: ;
      endcase
    end

    // Low counter
    if (lo_en) begin
      next_state.count_low_byte = state.count_low_byte + 8'h01;
      if (lo_wrap & split_mode & ~capture_enable) begin
        next_state.count_low_byte = state.reload_low_byte;
      end
    end

    // High counter
    if (hi_en) begin
      next_state.count_high_byte = state.count_high_byte + 8'h01;
      if (hi_wrap & split_mode & ~capture_enable) begin
        next_state.count_high_byte = state.reload_high_byte;
      end
    end

    // 16-bit wrap reloads both bytes
    if (hi_wrap & ~split_mode & ~capture_enable) begin
      next_state.count_low_byte  = state.reload_low_byte;
      next_state.count_high_byte = state.reload_high_byte;
    end

    // Flags: set wins over a software clear in the same cycle
    if (hi_wrap) begin
      next_state.ctrl[RCT_BIT_HIGH_OVF] = 1'b1;
    end
    if (lo_wrap) begin
      next_state.ctrl[RCT_BIT_LOW_OVF] = 1'b1;
    end

    // Capture takes the count before this cycle's increment
    if (capture_evt) begin
      next_state.reload_low_byte  = state.count_low_byte;
      next_state.reload_high_byte = state.count_high_byte;
    end

    // Interrupt request pulse
    if (i_timer_irq_enable) begin
      if (hi_wrap | (lo_wrap & low_irq_en) | capture_evt) begin
        next_state.irq_pulse = 1'b1;
      end
    end

    // Read data captured in the setup cycle
    next_state.rdata = '0;
    if (i_psel & ~i_penable & ~i_pwrite) begin
      unique case (i_paddr)
        RCT_OFF_CTRL:      next_state.rdata[7:0] = state.ctrl;
        RCT_OFF_CLK_SEL:   next_state.rdata[1:0] = state.clk_sel;
        RCT_OFF_RELOAD_LO: next_state.rdata[7:0] = state.reload_low_byte;
        RCT_OFF_RELOAD_HI: next_state.rdata[7:0] = state.reload_high_byte;
        RCT_OFF_COUNT_LO:  next_state.rdata[7:0] = state.count_low_byte;
        RCT_OFF_COUNT_HI:  next_state.rdata[7:0] = state.count_high_byte;
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state                  <= '0;
      state.ctrl             <= RCT_RST_BYTE;
      state.reload_low_byte  <= RCT_RST_BYTE;
      state.reload_high_byte <= RCT_RST_BYTE;
      state.count_low_byte   <= RCT_RST_BYTE;
      state.count_high_byte  <= RCT_RST_BYTE;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Zero wait states; wr_ctrl kept for readability of the write path
  assign o_pready      = 1'b1;
  assign o_pslverr     = apb_access & ~addr_ok & ~wr_ctrl;
  assign o_prdata      = state.rdata;
  assign o_irq_request = state.irq_pulse;

endmodule

/* File: include/rct_pkg.sv */
package rct_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] RCT_OFF_CTRL       = 8'hC8;
  localparam logic [7:0] RCT_OFF_CLK_SEL    = 8'hC9;
  localparam logic [7:0] RCT_OFF_RELOAD_LO  = 8'hCA;
  localparam logic [7:0] RCT_OFF_RELOAD_HI  = 8'hCB;
  localparam logic [7:0] RCT_OFF_COUNT_LO   = 8'hCC;
  localparam logic [7:0] RCT_OFF_COUNT_HI   = 8'hCD;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int RCT_BIT_HIGH_OVF   = 7;
  localparam int RCT_BIT_LOW_OVF    = 6;
  localparam int RCT_BIT_LOW_IRQ_EN = 5;
  localparam int RCT_BIT_CAPTURE_EN = 4;
  localparam int RCT_BIT_SPLIT      = 3;
  localparam int RCT_BIT_RUN        = 2;
  localparam int RCT_BIT_CAP_SRC    = 1;
  localparam int RCT_BIT_EXT_CLK    = 0;

  // Clock select register fields
  localparam int RCT_BIT_HI_SYSTEM_CLOCK  = 1;
  localparam int RCT_BIT_LO_SYSTEM_CLOCK  = 0;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] RCT_RST_BYTE     = 8'h00;
  localparam int         RCT_SYS_DIV      = 12;
  localparam int         RCT_EXT_DIV      = 8;
  localparam logic [3:0] RCT_SYS_DIV_LAST = 4'(RCT_SYS_DIV - 1);
  localparam logic [2:0] RCT_EXT_DIV_LAST = 3'(RCT_EXT_DIV - 1);
  localparam logic [7:0] RCT_BYTE_MAX     = 8'hFF;

endpackage

/* File: core/rct_sync_edge.sv */
`timescale 1ns/1ps
module rct_sync_edge
  import rct_pkg::*;
(
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  // Asynchronous level
  input  wire logic i_level,
  // Synchronous results
  output logic      o_rise,
  output logic      o_fall
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } rct_se_type;

  rct_se_type state;
  rct_se_type next_state;

  // First stage feeds only the second stage
  always_comb begin
    next_state      = state;
    next_state.meta = i_level;
    next_state.sync = state.meta;
    next_state.prev = state.sync;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // Single-cycle edge pulses
  assign o_rise = state.sync & ~state.prev;
  assign o_fall = ~state.sync & state.prev;

endmodule

/* File: core/rct_tick_gen.sv */
`timescale 1ns/1ps
module rct_tick_gen
  import rct_pkg::*;
(
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  // Synchronised external clock rising edge
  input  wire logic i_ext_rise,
  // Enable pulses
  output logic      o_sys_div_tick,
  output logic      o_ext_div_tick
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] sys_cnt;
    logic [2:0] ext_cnt;
  } rct_tg_type;

  rct_tg_type state;
  rct_tg_type next_state;

  always_comb begin
    next_state = state;
    if (state.sys_cnt == RCT_SYS_DIV_LAST) begin
      next_state.sys_cnt = '0;
    end else begin
      next_state.sys_cnt = state.sys_cnt + 4'h1;
    end
    if (i_ext_rise) begin
      next_state.ext_cnt = state.ext_cnt + 3'h1;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign o_sys_div_tick = (state.sys_cnt == RCT_SYS_DIV_LAST);
  assign o_ext_div_tick = i_ext_rise & (state.ext_cnt == RCT_EXT_DIV_LAST);

endmodule

/* File: verif/rct_timer_monitor.sv */
`timescale 1ns/1ps
module rct_timer_monitor
  import rct_pkg::*;
(
  // Clock and reset
  input wire logic        i_clk,
  input wire logic        i_rst,
  // APB
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [7:0]  i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0]  i_pstrb,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  // Events and interrupt
  input wire logic        i_ext_clk,
  input wire logic        i_usb_sof,
  input wire logic        i_lfo_clk,
  input wire logic        i_timer_irq_enable,
  input wire logic        o_irq_request
);
  // ----------------------------------------------------------------
  // Shadow of software-owned control bits
  // ----------------------------------------------------------------
  logic [5:0] sw;
  logic       quiet;
  logic       acc;
  assign acc = i_psel && i_penable;
  assign quiet = !sw[RCT_BIT_RUN] && !sw[RCT_BIT_SPLIT] && !sw[RCT_BIT_CAPTURE_EN];
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sw <= 6'h00;
    end else if (acc && i_pwrite && i_pstrb[0] && i_paddr == RCT_OFF_CTRL) begin
      sw <= i_pwdata[5:0];
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  a_ready_high: assert property (o_pready) else $error("pready low");
  a_err_in_access: assert property (o_pslverr |-> acc) else $error("stray pslverr");
  a_upper_zero: assert property (o_prdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  a_unmapped_read: assert property (acc && !i_pwrite && (i_paddr < 8'hC8 || i_paddr > 8'hCD)
    |-> o_pslverr && o_prdata == 32'h00000000) else $error("unmapped read wrong");
  a_ctrl_readback: assert property (acc && !i_pwrite && i_paddr == RCT_OFF_CTRL
    |-> o_prdata[5:0] == sw) else $error("control bits differ");
  a_irq_enabled: assert property (o_irq_request |-> $past(i_timer_irq_enable))
    else $error("irq while disabled");
  a_stopped_silent: assert property (o_irq_request |-> !$past(quiet))
    else $error("irq from stopped timer");
  a_sof_capture: assert property ($rose(i_usb_sof) && sw[4] && !sw[1] && i_timer_irq_enable
    |-> ##[2:6] o_irq_request) else $error("no capture irq");
  a_lfo_capture: assert property ($fell(i_lfo_clk) && sw[4] && sw[1] && i_timer_irq_enable
    |-> ##[2:6] o_irq_request) else $error("no capture irq");
  c_split_irq: cover property (o_irq_request && sw[RCT_BIT_SPLIT]);
  c_capture: cover property ($rose(i_usb_sof) && sw[RCT_BIT_CAPTURE_EN]);
  c_slverr: cover property (o_pslverr);
endmodule

/* File: verif/rct_timer_tb.sv */
`timescale 1ns/1ps
module rct_timer_tb
  import rct_pkg::*;
;
  logic        clk, rst, psel, penable, pwrite, ext_clk, sof, low_frequency_oscillator, irq_en;
  logic        pready, pslverr, irq, perr;
  logic [7:0]  paddr;
  logic [3:0]  pstrb;
  logic [31:0] pwdata, prdata, q;
  int          miscompares = 0, cmp_count = 0, cyc = 0, irq_cnt = 0, t_last = 0, t_prev = 0;
  int          ext_div = 0;

  rct_timer DUT (.i_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_ext_clk(ext_clk),
    .i_usb_sof(sof), .i_lfo_clk(low_frequency_oscillator), .i_timer_irq_enable(irq_en), .o_irq_request(irq));

  always #12.5 clk = ~clk;
  // External oscillator of six clocks, moved on the clock edge like every input
  always @(posedge clk) begin
    ext_div <= (ext_div == 2) ? 0 : ext_div + 1;
    if (ext_div == 2) begin
      ext_clk <= ~ext_clk;
    end
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (irq === 1'b1) begin
      irq_cnt <= irq_cnt + 1;
      t_prev <= t_last;
      t_last <= cyc;
    end
  end
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n == 50) begin
      miscompares++;
      tally_and_finish();
    end
    q = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    check(q, {24'h000000, e});
  endtask
  task automatic wait_irqs(input int n);
    int k;
    k = 0;
    while (irq_cnt < n && k < 3000) begin
      @(posedge clk);
      k++;
    end
    if (k == 3000) begin
      miscompares++;
      tally_and_finish();
    end
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    for (int a = 8'hC8; a <= 8'hCD; a++) begin
      rdc(8'(a), 8'h00);
    end
    for (int a = 8'hCA; a <= 8'hCD; a++) begin
      wr(8'(a), 8'(a) ^ 8'hA5);
      rdc(8'(a), 8'(a) ^ 8'hA5);
      wr(8'(a), 8'h00);
    end
    apb(1'b0, 8'hD0, 8'h00);
    check(q, 32'h00000000);
    check({31'h0, perr}, 32'h00000001);
  endtask
  task automatic t_auto16();
    int n0;
    n0 = irq_cnt;
    wr(8'hC9, 8'h01);
    wr(8'hCA, 8'h34);
    wr(8'hCB, 8'h12);
    wr(8'hCC, 8'hF0);
    wr(8'hCD, 8'hFF);
    wr(8'hC8, 8'h04);
    wait_irqs(n0 + 1);
    rdc(8'hC8, 8'hC4);
    wr(8'hC8, 8'hC0);
    rdc(8'hCD, 8'h12);
    check(irq_cnt, n0 + 1);
    repeat (300) @(posedge clk);
    rdc(8'hC8, 8'hC0);
    wr(8'hC8, 8'h00);
    rdc(8'hC8, 8'h00);
  endtask
  task automatic t_low_irq();
    int n0;
    n0 = irq_cnt;
    wr(8'hCD, 8'h00);
    wr(8'hCC, 8'hF0);
    wr(8'hC8, 8'h04);
    repeat (40) @(posedge clk);
    rdc(8'hC8, 8'h44);
    check(irq_cnt, n0);
    wr(8'hCC, 8'hF0);
    wr(8'hC8, 8'h24);
    wait_irqs(n0 + 1);
    rdc(8'hC8, 8'h64);
    wr(8'hC8, 8'h00);
  endtask
  task automatic t_split();
    int m, b, n0, gap;
    for (int k = 0; k < 6; k++) begin
      m = k % 3;
      b = k / 3;
      for (int a = 8'hCA; a <= 8'hCD; a++) wr(8'(a), 8'hFE);
      wr(8'hC9, (m == 0) ? 8'h03 : 8'h00);
      n0 = irq_cnt;
      // Low test keeps high stopped; high test leaves low irqs masked
      wr(8'hC8, 8'h08 | 8'(m == 2) | (b ? 8'h04 : 8'h20));
      wait_irqs(n0 + 3);
      gap = t_last - t_prev;
      rdc(8'hC8, 8'h08 | 8'(m == 2) | (b ? 8'hC4 : 8'h60));
      wr(8'hC8, 8'h00);
      if (m == 2) check(gap, 2 * RCT_EXT_DIV * 6);
      else check(gap, m ? 24 : 2);
    end
  endtask
  task automatic t_capture();
    int n0;
    // Bit 0 picks the source, bit 1 the interrupt enable
    for (int s = 0; s < 4; s++) begin
      wr(8'hCC, s[0] ? 8'h57 : 8'hCD);
      wr(8'hCD, s[0] ? 8'h13 : 8'hAB);
      wr(8'hCA, 8'h00);
      wr(8'hCB, 8'h00);
      wr(8'hC8, s[0] ? 8'h12 : 8'h10);
      n0 = irq_cnt;
      irq_en <= s[1];
      @(posedge clk);
      if (s[0]) sof <= 1'b1;
      else low_frequency_oscillator <= 1'b0;
      repeat (10) @(posedge clk);
      sof <= 1'b0;
      low_frequency_oscillator <= 1'b1;
      repeat (10) @(posedge clk);
      rdc(8'hCA, 8'h00);
      if (s[0]) low_frequency_oscillator <= 1'b0;
      else sof <= 1'b1;
      repeat (10) @(posedge clk);
      sof <= 1'b0;
      low_frequency_oscillator <= 1'b1;
      repeat (10) @(posedge clk);
      check(irq_cnt, n0 + (s / 2));
      rdc(8'hCA, s[0] ? 8'h57 : 8'hCD);
      rdc(8'hCB, s[0] ? 8'h13 : 8'hAB);
      wr(8'hC8, 8'h00);
    end
  endtask

  initial begin
    clk = 1'b0;
    ext_clk = 1'b0;
    rst = 1'b1;
    {psel, penable, pwrite, sof} = 4'h0;
    low_frequency_oscillator = 1'b1;
    irq_en = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    pstrb = 4'hF;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_auto16();
    t_low_irq();
    t_split();
    t_capture();
    tally_and_finish();
  end
endmodule

bind rct_timer rct_timer_monitor MON (.i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
  .i_pstrb(i_pstrb), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .i_ext_clk(i_ext_clk), .i_usb_sof(i_usb_sof), .i_lfo_clk(i_lfo_clk),
  .i_timer_irq_enable(i_timer_irq_enable), .o_irq_request(o_irq_request));
